//--- rtl/bqf_filter.sv
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Function
// - each queue allocation that satisfies the programmed mask gives one count event, but a counter with edge bit 24 set counts a back-to-back run once.
// - the event goes only through event select code 5 and drives only counters 0 and 1.
// - mask bits 1:0 of selector bits 24:9 pick read, read-invalidate, write or writeback.
// - mask bits 3:2 pick zero, one or eight chunks by codes 0, 1 and 3.
// - mask bit 5 set requires an input or output request.
// - mask bit 6 set requires a locked request.
// - mask bit 7 set requires a cacheable request.
// - mask bit 8 set requires a chunk split across an 8-byte boundary.
// - mask bit 9 picks demand requests when set and prefetches when clear.
// - mask bit 10 set requires an ordered request.
// - mask bits 13:11 pick memory kind by codes 0, 1, 4, 5 and 6.
module bqf_filter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input bqf_pkg::bqf_req_t alloc,
    output logic [1:0] count_event
);
    bqf_pkg::bqf_st_t st_r;
    bqf_pkg::bqf_st_t st_nxt;
    logic hit;
    logic aph;
    logic sel_ok;
    logic [1:0] cc_ok;
    logic [1:0] edge_md;

    function automatic logic [31:0] reg_read(input bqf_pkg::bqf_st_t s,
                                             input logic [31:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a[31:8] == 24'h00_0000) begin
            case (a[7:0])
                bqf_pkg::BQF_ESC_OFS: v = s.evsel;
                bqf_pkg::BQF_CC0_OFS: v = s.cnt_cfg0;
                bqf_pkg::BQF_CC1_OFS: v = s.cnt_cfg1;
                bqf_pkg::BQF_STAT_OFS: begin
                    v[12:0] = s.last_attr;
                    v[bqf_pkg::BQF_STAT_HIT_BIT] = s.last_hit;
                end
                default: v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    bqf_match u_match (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(alloc),
        .mask(st_r.evsel[bqf_pkg::BQF_MASK_MSB:bqf_pkg::BQF_MASK_LSB]),
        .hit(hit)
    );

    always_comb begin
        st_nxt = st_r;
        aph = hsel && htrans[1] && hready;
        // data phase of a pending write
        if (st_r.wr_pend) begin
            case (st_r.wr_ofs)
                bqf_pkg::BQF_ESC_OFS: st_nxt.evsel = hwdata;
                bqf_pkg::BQF_CC0_OFS: st_nxt.cnt_cfg0 = hwdata;
                bqf_pkg::BQF_CC1_OFS: st_nxt.cnt_cfg1 = hwdata;
                default: st_nxt.evsel = st_r.evsel;
            endcase
        end
        st_nxt.wr_pend = aph && hwrite && (haddr[31:8] == 24'h00_0000);
        st_nxt.wr_ofs = haddr[7:0];
        if (aph && !hwrite) begin
            st_nxt.rdata = reg_read(st_nxt, haddr);
        end
        // gating: event select code 5, counters 0 and 1 only
        sel_ok = st_r.evsel[bqf_pkg::BQF_EVSEL_MSB:bqf_pkg::BQF_EVSEL_LSB]
            == bqf_pkg::BQF_ALLOC_EVSEL;
        cc_ok[0] = bqf_pkg::bqf_cc_ok(st_r.cnt_cfg0);
        cc_ok[1] = bqf_pkg::bqf_cc_ok(st_r.cnt_cfg1);
        edge_md[0] = st_r.cnt_cfg0[bqf_pkg::BQF_CC_EDGE_BIT];
        edge_md[1] = st_r.cnt_cfg1[bqf_pkg::BQF_CC_EDGE_BIT];
        for (int i = 0; i < 2; i++) begin
            st_nxt.cnt[i] = hit && sel_ok && cc_ok[i] && (!edge_md[i] || !st_r.prev_hit);
        end
        st_nxt.prev_hit = hit;
        // status capture
        st_nxt.vld_d = alloc.valid;
        if (alloc.valid) begin
            st_nxt.last_attr = alloc.attr;
        end
        if (st_r.vld_d) begin
            st_nxt.last_hit = hit;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.evsel <= bqf_pkg::BQF_ESC_RST;
            st_r.cnt_cfg0 <= bqf_pkg::BQF_CCC_RST;
            st_r.cnt_cfg1 <= bqf_pkg::BQF_CCC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
    assign count_event = st_r.cnt;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    count_level_a: assert property (hit && st_r.evsel[31:25] == 7'h05
        && st_r.cnt_cfg0[12] && st_r.cnt_cfg0[15:13] == 3'h7 && !st_r.cnt_cfg0[24]
        |=> count_event[0])
        else $error("qualified allocation not counted");
    count_edge_a: assert property (hit && st_r.prev_hit && st_r.cnt_cfg0[24]
        |=> !count_event[0])
        else $error("back to back match counted twice in edge mode");
    selector_gate_a: assert property (st_r.evsel[31:25] != 7'h05
        |=> count_event == 2'b00)
        else $error("count without allocation event select");
    count_cause_a: assert property (count_event[1] |-> $past(hit)
        && $past(st_r.cnt_cfg1[15:13]) == 3'h7)
        else $error("count without matching allocation");
endmodule // bqf_filter

//--- rtl/bqf_match.sv
`timescale 1ns/1ps
module bqf_match (
    input wire logic hclk,
    input wire logic hresetn,
    input bqf_pkg::bqf_req_t req,
    input wire logic [15:0] mask,
    output logic hit
);
    bqf_pkg::bqf_match_st_t st_r;
    bqf_pkg::bqf_match_st_t st_nxt;
    logic kind_ok;
    logic size_ok;
    logic flag_ok;
    logic mem_ok;

    always_comb begin
        kind_ok = req.attr.kind == mask[bqf_pkg::BQF_KIND_LSB +: 2];
        size_ok = bqf_pkg::bqf_size_legal(mask[bqf_pkg::BQF_SIZE_LSB +: 2])
            && (req.attr.size == mask[bqf_pkg::BQF_SIZE_LSB +: 2]);
        flag_ok = (!mask[bqf_pkg::BQF_IO_BIT] || req.attr.io)
            && (!mask[bqf_pkg::BQF_LOCK_BIT] || req.attr.lock)
            && (!mask[bqf_pkg::BQF_CACHE_BIT] || req.attr.cache)
            && (!mask[bqf_pkg::BQF_SPLIT_BIT] || req.attr.split)
            && (req.attr.demand == mask[bqf_pkg::BQF_DEMAND_BIT])
            && (!mask[bqf_pkg::BQF_ORDER_BIT] || req.attr.ordered);
        mem_ok = bqf_pkg::bqf_mem_legal(mask[bqf_pkg::BQF_MEM_LSB +: 3])
            && (req.attr.mem == mask[bqf_pkg::BQF_MEM_LSB +: 3]);
        st_nxt.hit = req.valid && kind_ok && size_ok && flag_ok && mem_ok;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hit = st_r.hit;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    kind_match_a: assert property (req.valid && req.attr.kind != mask[1:0] |=> !hit)
        else $error("request kind mismatch counted");
    size_match_a: assert property (req.valid && mask[3:2] == 2'h2 |=> !hit)
        else $error("reserved size code matched");
    io_flag_a: assert property (req.valid && mask[5] && !req.attr.io |=> !hit)
        else $error("io qualifier ignored");
    lock_flag_a: assert property (req.valid && mask[6] && !req.attr.lock |=> !hit)
        else $error("lock qualifier ignored");
    cache_flag_a: assert property (req.valid && mask[7] && !req.attr.cache |=> !hit)
        else $error("cacheable qualifier ignored");
    split_flag_a: assert property (req.valid && mask[8] && !req.attr.split |=> !hit)
        else $error("split qualifier ignored");
    demand_sel_a: assert property (hit |-> $past(req.attr.demand) == $past(mask[9]))
        else $error("demand or prefetch selection wrong");
    order_flag_a: assert property (req.valid && mask[10] && !req.attr.ordered |=> !hit)
        else $error("ordered qualifier ignored");
    mem_match_a: assert property (hit |-> $past(req.attr.mem) == $past(mask[13:11]))
        else $error("memory kind mismatch counted");
    full_match_a: assert property (req.valid && mask[1:0] == req.attr.kind
        && mask[3:2] == 2'h1 && req.attr.size == 2'h1 && mask[8:5] == 4'h0
        && mask[10] == 1'b0 && mask[9] == req.attr.demand
        && mask[13:11] == 3'h6 && req.attr.mem == 3'h6 |=> hit)
        else $error("fully matching allocation not flagged");
endmodule // bqf_match

//--- rtl/bqf_pkg.sv
package bqf_pkg;
    // register byte offsets
    localparam logic [7:0] BQF_ESC_OFS = 8'h00;
    localparam logic [7:0] BQF_CC0_OFS = 8'h04;
    localparam logic [7:0] BQF_CC1_OFS = 8'h08;
    localparam logic [7:0] BQF_STAT_OFS = 8'h0c;
    localparam logic [31:0] BQF_ESC_RST = 32'h0000_0000;
    localparam logic [31:0] BQF_CCC_RST = 32'h0000_0000;

    // event_selection_control fields
    localparam int BQF_MASK_LSB = 9;
    localparam int BQF_MASK_MSB = 24;
    localparam int BQF_EVSEL_LSB = 25;
    localparam int BQF_EVSEL_MSB = 31;
    localparam logic [6:0] BQF_ALLOC_EVSEL = 7'h05;

    // counter_configuration_control fields
    localparam int BQF_CC_EN_BIT = 12;
    localparam int BQF_CC_SEL_LSB = 13;
    localparam int BQF_CC_SEL_MSB = 15;
    localparam int BQF_CC_EDGE_BIT = 24;
    localparam logic [2:0] BQF_ALLOC_CCSEL = 3'h7;

    // event mask bit positions
    localparam int BQF_KIND_LSB = 0;
    localparam int BQF_SIZE_LSB = 2;
    localparam int BQF_IO_BIT = 5;
    localparam int BQF_LOCK_BIT = 6;
    localparam int BQF_CACHE_BIT = 7;
    localparam int BQF_SPLIT_BIT = 8;
    localparam int BQF_DEMAND_BIT = 9;
    localparam int BQF_ORDER_BIT = 10;
    localparam int BQF_MEM_LSB = 11;

    // status fields
    localparam int BQF_STAT_HIT_BIT = 16;

    // request size encodings
    localparam logic [1:0] BQF_SIZE_ZERO = 2'h0;
    localparam logic [1:0] BQF_SIZE_ONE = 2'h1;
    localparam logic [1:0] BQF_SIZE_EIGHT = 2'h3;

    // memory kind encodings
    localparam logic [2:0] BQF_MEM_UNCACHEABLE = 3'h0;
    localparam logic [2:0] BQF_MEM_SPEC_COMBINED = 3'h1;
    localparam logic [2:0] BQF_MEM_WRITE_THROUGH = 3'h4;
    localparam logic [2:0] BQF_MEM_WP = 3'h5;
    localparam logic [2:0] BQF_MEM_WRITE_BACK = 3'h6;

    typedef struct packed {
        logic [2:0] mem;
        logic ordered;
        logic demand;
        logic split;
        logic cache;
        logic lock;
        logic io;
        logic [1:0] size;
        logic [1:0] kind;
    } bqf_attr_t;

    typedef struct packed {
        logic valid;
        bqf_attr_t attr;
    } bqf_req_t;

    typedef struct packed {
        logic hit;
    } bqf_match_st_t;

    typedef struct packed {
        logic [31:0] evsel;
        logic [31:0] cnt_cfg0;
        logic [31:0] cnt_cfg1;
        logic wr_pend;
        logic [7:0] wr_ofs;
        logic [31:0] rdata;
        logic vld_d;
        bqf_attr_t last_attr;
        logic last_hit;
        logic prev_hit;
        logic [1:0] cnt;
    } bqf_st_t;

    function automatic logic bqf_size_legal(input logic [1:0] s);
        return (s == BQF_SIZE_ZERO) || (s == BQF_SIZE_ONE) || (s == BQF_SIZE_EIGHT);
    endfunction

    function automatic logic bqf_mem_legal(input logic [2:0] m);
        return (m == BQF_MEM_UNCACHEABLE) || (m == BQF_MEM_SPEC_COMBINED) ||
               (m == BQF_MEM_WRITE_THROUGH) || (m == BQF_MEM_WP) ||
               (m == BQF_MEM_WRITE_BACK);
    endfunction

    function automatic logic bqf_cc_ok(input logic [31:0] c);
        return c[BQF_CC_EN_BIT] && (c[BQF_CC_SEL_MSB:BQF_CC_SEL_LSB] == BQF_ALLOC_CCSEL);
    endfunction
endpackage

//--- testbench/bqf_filter_tb_top.sv
`timescale 1ns/1ps
module bqf_filter_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    bqf_pkg::bqf_req_t alloc = '0;
    logic [1:0] count_event;
    int num_errors = 0;
    int compares = 0;
    logic [31:0] rd;
    logic [12:0] m;
    logic [12:0] a;
    int pos[3] = '{0, 2, 10};
    localparam logic [12:0] BASE = 13'h1804;

    always #5 hclk = ~hclk;

    bqf_filter dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .alloc(alloc),
        .count_event(count_event)
    );

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask

    // one single transfer, returns at the edge closing the data phase
    task automatic ahb(input logic wr, input logic [31:0] ad, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= ad;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // mask layout seen from the attribute vector
    function automatic logic [31:0] sel_word(input logic [12:0] x);
        return {7'h05, 2'h0, x[12:4], 1'b0, x[3:0], 9'h0};
    endfunction

    function automatic logic hit(input logic [12:0] x, input logic [12:0] y);
        return x[1:0] == y[1:0] && x[3:2] == y[3:2] && x[3:2] != 2'h2 &&
               x[12:10] == y[12:10] && !(x[12:10] inside {3'h2, 3'h3, 3'h7}) &&
               (x[9:4] & ~y[9:4] & 6'h2f) == 6'h0 && x[8] == y[8];
    endfunction

    // single allocation, pulse expected two cycles later
    task automatic send(input logic [12:0] x, input logic [1:0] e);
        alloc <= bqf_pkg::bqf_req_t'({1'b1, x});
        @(posedge hclk);
        alloc.valid <= 1'b0;
        @(posedge hclk);
        #1 chk("count_event", {30'h0, e}, {30'h0, count_event});
        @(posedge hclk);
    endtask

    task finish_test;
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #500000;
        num_errors++;
        finish_test;
    end

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 5; i++) begin
            ahb(1'b0, 32'(4 * i), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        ahb(1'b1, 32'h10, 32'hffff_ffff);
        ahb(1'b0, 32'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 32'h4, 32'h0000_f000);
        ahb(1'b1, 32'h8, 32'h0000_f000);
        ahb(1'b0, 32'h8, 32'h0);
        chk("cc1", 32'h0000_f000, rd);
        ahb(1'b0, 32'h104, 32'h0);
        chk("alias", 32'h0, rd);
        for (int f = 0; f < 3; f++) begin
            for (int v = 0; v < 8; v++) begin
                for (int w = 0; w < 8; w++) begin
                    if (f < 2 && (v > 3 || w > 3)) continue;
                    m = (BASE & ~(13'h7 << pos[f])) | (13'(v) << pos[f]);
                    a = (BASE & ~(13'h7 << pos[f])) | (13'(w) << pos[f]);
                    ahb(1'b1, 32'h0, sel_word(m));
                    send(a, hit(m, a) ? 2'b11 : 2'b00);
                end
            end
        end
        for (int b = 4; b < 10; b++) begin
            for (int k = 0; k < 4; k++) begin
                m = BASE | (13'(k & 1) << b);
                a = BASE | (13'(k >> 1) << b);
                ahb(1'b1, 32'h0, sel_word(m));
                send(a, hit(m, a) ? 2'b11 : 2'b00);
            end
        end
        ahb(1'b1, 32'hc, 32'h0);
        ahb(1'b0, 32'hc, 32'h0);
        chk("status", {15'h0, 1'b1, 3'h0, BASE | 13'h200}, rd);
        ahb(1'b1, 32'h0, sel_word(BASE) ^ 32'h2000_0000);
        send(BASE, 2'b00);
        ahb(1'b1, 32'h0, sel_word(BASE));
        ahb(1'b1, 32'h8, 32'h0000_d000);
        send(BASE, 2'b01);
        ahb(1'b1, 32'h4, 32'h0000_e000);
        ahb(1'b1, 32'h8, 32'h0000_f000);
        send(BASE, 2'b10);
        ahb(1'b1, 32'h4, 32'h0100_f000);
        alloc <= bqf_pkg::bqf_req_t'({1'b1, BASE});
        repeat (2) @(posedge hclk);
        alloc.valid <= 1'b0;
        #1 chk("edge first", 32'h3, {30'h0, count_event});
        @(posedge hclk);
        #1 chk("edge second", 32'h2, {30'h0, count_event});
        @(posedge hclk);
        finish_test;
    end
endmodule // bqf_filter_tb_top
